// >>> mmas_consts.svh
// Purpose: Constants of the multi-module arm sequencer
// Assumes: Registers addressed by decimal offset, 16-bit data
// Notes: Command values and field positions for the control register
`ifndef MMAS_CONSTS_SVH
`define MMAS_CONSTS_SVH
`define MMAS_REG_MEAS_STATE 6'h0A
`define MMAS_REG_INPUT_PATH 6'h0B
`define MMAS_CMD_PULSE 16'h0002
`define MMAS_CMD_WAIT 16'h0003
`define MMAS_CMD_LEAD 16'h0007
`define MMAS_CMD_ARM 16'h0001
`define MMAS_CMD_IDLE 16'h0000
`define MMAS_PATH_LSB 0
`define MMAS_PATH_MSB 1
`define MMAS_PATH_RESET 2'h0
`define MMAS_ST_LSB 0
`define MMAS_ST_MSB 2
`define MMAS_LEAD_BIT 4
`define MMAS_PULSE_CYCLES 4'h4
`endif

// >>> mmas_pkg.sv
// Purpose: Types of the multi-module arm sequencer
// Assumes: Included constants header
// Notes: Types only
package mmas_pkg;
    typedef enum logic [2:0] {
        MMAS_IDLE = 3'b000,
        MMAS_NORMAL = 3'b001,
        MMAS_ARMED = 3'b010,
        MMAS_TRIG = 3'b011
    } mmas_state_e;
    typedef enum logic [1:0] {
        MMAS_PATH_DC = 2'b00,
        MMAS_PATH_AC = 2'b01,
        MMAS_PATH_GND = 2'b10
    } mmas_path_e;
endpackage

// >>> mmas_pulse_gen.sv
// Purpose: Fixed-length pulse generator for the alignment line
// Assumes: Start is a one-cycle request
// Notes: Retrigger restarts the count
`timescale 1ns/1ps
`default_nettype none
`include "mmas_consts.svh"
module mmas_pulse_gen #(
    parameter logic [3:0] LEN = `MMAS_PULSE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    output logic active
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (ce) begin
            if (start) begin
                cnt_q <= LEN;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
    assign active = (cnt_q != 4'h0);
endmodule
`default_nettype wire

// >>> mmas_top.sv
// Purpose: Measurement-state sequencer with multi-module alignment line
// Assumes: Register port synchronous to CORE_CLK, alignment line sampled directly
// Notes: Alignment line is open-drain style: driven high only while pulsing
`timescale 1ns/1ps
`default_nettype none
`include "mmas_consts.svh"
// Function
// - Arm command moves idle to armed
// - Armed waits for trigger, then trigger state
// - Measurement-state register at decimal offset ten
// - Value 3: idle, normal, wait, no drive
// - Value 7: idle, normal, then drive line
// - Value 2 on master pulses line
// - Line pulse moves all modules in normal to trigger
// - Input path direct, capacitive or grounded
module mmas_top
    import mmas_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic TRIG_IN,
    input wire logic ALIGN_IN,
    output logic ALIGN_OUT,
    output logic ALIGN_OE,
    output logic [2:0] MEAS_STATE,
    output logic [1:0] INPUT_PATH
);
    mmas_state_e state_q;
    mmas_state_e state_d;
    mmas_path_e path_q;
    logic lead_q;
    logic align_prev_q;
    logic pulse_start;
    logic pulse_active;
    logic align_rise;
    logic wr_meas;
    logic wr_path;
    logic rd_meas;
    logic rd_path;
    logic [DATA_W-1:0] rdata_d;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction

    // Full-word compare, so stray upper bits never alias a command
    function automatic logic cmd_is(input logic [DATA_W-1:0] d, input logic [15:0] c);
        cmd_is = (d == DATA_W'(c));
    endfunction

    assign wr_meas = REG_WR && hit(REG_ADDR, `MMAS_REG_MEAS_STATE);
    assign wr_path = REG_WR && hit(REG_ADDR, `MMAS_REG_INPUT_PATH);
    // Read decode kept apart so the answer mux stays combinational
    assign rd_meas = REG_RD && hit(REG_ADDR, `MMAS_REG_MEAS_STATE);
    assign rd_path = REG_RD && hit(REG_ADDR, `MMAS_REG_INPUT_PATH);
    // Only a leading module may pulse; a waiting slave ignores value 2
    assign pulse_start = wr_meas && cmd_is(REG_WDATA, `MMAS_CMD_PULSE) && lead_q;
    // Edge of the shared line, own pulse included, so all advance alike
    assign align_rise = ALIGN_IN && !align_prev_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MMAS_IDLE: begin
                // Idle is left only through a register write
                state_d = MMAS_IDLE;
            end
            MMAS_NORMAL: begin
                if (align_rise) begin
                    state_d = MMAS_TRIG;
                end
            end
            MMAS_ARMED: begin
                if (TRIG_IN) begin
                    state_d = MMAS_TRIG;
                end
            end
            MMAS_TRIG: begin
                state_d = MMAS_TRIG;
            end
            default: begin
                state_d = MMAS_IDLE;
            end
        endcase

        // Values 3 and 7 move straight to normal in one step, with no idle cycle between
        if (wr_meas) begin
            unique case (REG_WDATA)
                `MMAS_CMD_ARM: begin
                    if (state_q == MMAS_IDLE) begin
                        state_d = MMAS_ARMED;
                    end
                end
                `MMAS_CMD_WAIT: begin
                    state_d = MMAS_NORMAL;
                end
                `MMAS_CMD_LEAD: begin
                    state_d = MMAS_NORMAL;
                end
                `MMAS_CMD_IDLE: begin
                    state_d = MMAS_IDLE;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= MMAS_IDLE;
        end else if (CLK_EN) begin
            state_q <= state_d;
        end
    end

    // Lead survives value 2 so a pulse may follow value 7
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lead_q <= 1'b0;
        end else if (CLK_EN && wr_meas) begin
            if (cmd_is(REG_WDATA, `MMAS_CMD_LEAD)) begin
                lead_q <= 1'b1;
            end else if (!cmd_is(REG_WDATA, `MMAS_CMD_PULSE)) begin
                lead_q <= 1'b0;
            end
        end
    end

    // Resets low like the pulled-down line, so no false edge after reset
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            align_prev_q <= 1'b0;
        end else if (CLK_EN) begin
            align_prev_q <= ALIGN_IN;
        end
    end

    // Unused code 3 falls back to direct coupling
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            path_q <= MMAS_PATH_DC;
        end else if (CLK_EN && wr_path) begin
            unique case (REG_WDATA[`MMAS_PATH_MSB:`MMAS_PATH_LSB])
                MMAS_PATH_AC: begin
                    path_q <= MMAS_PATH_AC;
                end
                MMAS_PATH_GND: begin
                    path_q <= MMAS_PATH_GND;
                end
                default: begin
                    path_q <= MMAS_PATH_DC;
                end
            endcase
        end
    end

    mmas_pulse_gen u_pulse (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .ce(CLK_EN),
        .start(pulse_start),
        .active(pulse_active)
    );

    // Registered line drive keeps the output glitch free
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ALIGN_OUT <= 1'b0;
            ALIGN_OE <= 1'b0;
        end else if (CLK_EN) begin
            ALIGN_OUT <= pulse_active;
            ALIGN_OE <= pulse_active;
        end
    end

    // Path output trails its register by one cycle
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            MEAS_STATE <= MMAS_IDLE;
            INPUT_PATH <= `MMAS_PATH_RESET;
        end else if (CLK_EN) begin
            MEAS_STATE <= state_d;
            INPUT_PATH <= path_q;
        end
    end

    // Unmapped or absent reads return zero
    always_comb begin
        rdata_d = '0;
        if (rd_meas) begin
            rdata_d[`MMAS_ST_MSB:`MMAS_ST_LSB] = state_q;
            rdata_d[`MMAS_LEAD_BIT] = lead_q;
        end else if (rd_path) begin
            rdata_d[`MMAS_PATH_MSB:`MMAS_PATH_LSB] = path_q;
        end
    end

    // Answer stands for one enabled cycle
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= '0;
            REG_RVALID <= 1'b0;
        end else if (CLK_EN) begin
            REG_RVALID <= REG_RD;
            REG_RDATA <= rdata_d;
        end
    end
endmodule
`default_nettype wire

// >>> mmas_peer.sv
// Purpose: Peer module on the shared alignment line
// Assumes: Line is wired-OR with a pull-down
// Notes: Drives a four-cycle pulse per request
`timescale 1ns/1ps
`default_nettype none
module mmas_peer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    output logic drive
);
    logic [2:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
        end else if (go) begin
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    // Released line falls to the pull-down level
    assign drive = (cnt_q != 3'h0);
endmodule
`default_nettype wire

// >>> mmas_chk.sv
// Purpose: Port checker of the arm sequencer
// Assumes: CLK_EN stays high while the line pulses
// Notes: Bound to every mmas_top
`timescale 1ns/1ps
`default_nettype none
module mmas_chk #(
    parameter int DATA_W = 16
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [5:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_RVALID,
    input wire logic TRIG_IN,
    input wire logic ALIGN_IN,
    input wire logic ALIGN_OUT,
    input wire logic ALIGN_OE,
    input wire logic [2:0] MEAS_STATE,
    input wire logic [1:0] INPUT_PATH
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    wire logic wr = CLK_EN && REG_WR && REG_ADDR == 6'h0A;
    wire logic quiet = CLK_EN && !REG_WR;
    property p_arm;
        wr && REG_WDATA == 16'h0001 && MEAS_STATE == 3'h0 |=> MEAS_STATE == 3'h2;
    endproperty
    a_arm: assert property (p_arm) else $error("arm did not reach armed");
    property p_trig;
        quiet && MEAS_STATE == 3'h2 |=> MEAS_STATE == ($past(TRIG_IN) ? 3'h3 : 3'h2);
    endproperty
    a_trig: assert property (p_trig) else $error("armed state left wrongly");
    property p_rvalid;
        CLK_EN && REG_RD |=> REG_RVALID;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_wait;
        wr && REG_WDATA == 16'h0003 |=> MEAS_STATE == 3'h1;
    endproperty
    a_wait: assert property (p_wait) else $error("wait value did not reach normal");
    property p_lead;
        wr && REG_WDATA == 16'h0007 |=> MEAS_STATE == 3'h1;
    endproperty
    a_lead: assert property (p_lead) else $error("lead value did not reach normal");
    property p_pulse;
        $rose(ALIGN_OE) |-> (ALIGN_OUT && ALIGN_OE)[*4] ##1 !ALIGN_OE;
    endproperty
    a_pulse: assert property (p_pulse) else $error("line pulse length wrong");
    property p_align;
        quiet && $past(CLK_EN) && MEAS_STATE == 3'h1 && ALIGN_IN && !$past(ALIGN_IN)
            |=> MEAS_STATE == 3'h3;
    endproperty
    a_align: assert property (p_align) else $error("line pulse did not trigger");
    property p_rst;
        $rose(RST_N) |-> MEAS_STATE == 3'h0 && !ALIGN_OE && INPUT_PATH == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    property p_path;
        CLK_EN && REG_WR && REG_ADDR == 6'h0B && REG_WDATA[1:0] != 2'h3 ##1 CLK_EN
            |=> INPUT_PATH == $past(REG_WDATA[1:0], 2);
    endproperty
    a_path: assert property (p_path) else $error("input path not applied");
    c_path: cover property (INPUT_PATH == 2'h2);
    c_armed: cover property (MEAS_STATE == 3'h2);
    c_drive: cover property (ALIGN_OE);
    c_trig: cover property (MEAS_STATE == 3'h3);
endmodule
bind mmas_top mmas_chk #(.DATA_W(DATA_W)) u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .CLK_EN(CLK_EN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID), .TRIG_IN(TRIG_IN), .ALIGN_IN(ALIGN_IN),
    .ALIGN_OUT(ALIGN_OUT), .ALIGN_OE(ALIGN_OE), .MEAS_STATE(MEAS_STATE),
    .INPUT_PATH(INPUT_PATH));
`default_nettype wire

// >>> tb_multi_module_arm_sync.sv
// Purpose: Bench of the arm sequencer with one peer
// Assumes: Alignment line is the OR of both drivers
// Notes: Reads are checked in order through a queue
`timescale 1ns/1ps
`default_nettype none
module tb_multi_module_arm_sync;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, trig = 0, go = 0, ce = 1;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000, rdata, q[$];
    logic rvalid, a_out, a_oe, peer;
    logic [2:0] st;
    logic [1:0] path;
    int num_errors = 0, checks_done = 0;
    wire logic align = (a_out & a_oe) | peer;
    always #25 clk = ~clk;
    mmas_top dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(ce), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .TRIG_IN(trig), .ALIGN_IN(align), .ALIGN_OUT(a_out), .ALIGN_OE(a_oe),
        .MEAS_STATE(st), .INPUT_PATH(path));
    mmas_peer peer_model (.clk(clk), .rst_n(rst_n), .go(go), .drive(peer));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 0;
        rd = 0;
    endtask
    task automatic rdq(input logic [5:0] a, input logic [15:0] e);
        q.push_back(e);
        acc(0, a, 16'h0000);
    endtask
    always @(negedge clk) if (rvalid === 1'b1) chk("REG_RDATA", rdata, q.pop_front());
    task automatic tally_and_finish();
        chk("pending reads", 16'(q.size()), 16'h0000);
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #150000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(12));
        repeat (6) @(posedge clk);
        @(negedge clk) rst_n = 1;
        rdq(6'h0A, 16'h0000);
        rdq(6'h0B, 16'h0000);
        rdq(6'h0C, 16'h0000);
        for (int p = 0; p < 3; p++) begin
            acc(1, 6'h0B, 16'(p));
            rdq(6'h0B, 16'(p));
            chk("INPUT_PATH", 16'(path), 16'(p));
        end
        // Frozen clock enable must swallow a write
        @(negedge clk) ce = 0;
        acc(1, 6'h0B, 16'h0001);
        ce = 1;
        rdq(6'h0B, 16'h0002);
        chk("INPUT_PATH", 16'(path), 16'h0002);
        // Unmapped and undefined writes must leave idle untouched
        acc(1, 6'h14 + 6'($urandom_range(7)), 16'($urandom));
        acc(1, 6'h0A, 16'h0004 + 16'($urandom_range(2)));
        rdq(6'h0A, 16'h0000);
        acc(1, 6'h0A, 16'h0001);
        rdq(6'h0A, 16'h0002);
        trig = 1;
        @(negedge clk);
        trig = 0;
        chk("MEAS_STATE", 16'(st), 16'h0003);
        acc(1, 6'h0A, 16'h0003);
        rdq(6'h0A, 16'h0001);
        go = 1;
        @(negedge clk);
        go = 0;
        repeat (3) @(negedge clk);
        chk("ALIGN_OE", 16'(a_oe), 16'h0000);
        chk("MEAS_STATE", 16'(st), 16'h0003);
        acc(1, 6'h0A, 16'h0000);
        acc(1, 6'h0A, 16'h0002);
        rdq(6'h0A, 16'h0000);
        chk("ALIGN_OE", 16'(a_oe), 16'h0000);
        acc(1, 6'h0A, 16'h0007);
        rdq(6'h0A, 16'h0011);
        acc(1, 6'h0A, 16'h0002);
        repeat (3) @(negedge clk);
        chk("ALIGN_OE", 16'(a_oe), 16'h0001);
        chk("ALIGN_OUT", 16'(a_out), 16'h0001);
        repeat (4) @(negedge clk);
        chk("MEAS_STATE", 16'(st), 16'h0003);
        // Reset in mid-run, from trigger state with lead set
        @(negedge clk) rst_n = 0;
        @(negedge clk) rst_n = 1;
        chk("INPUT_PATH", 16'(path), 16'h0000);
        chk("ALIGN_OE", 16'(a_oe), 16'h0000);
        rdq(6'h0A, 16'h0000);
        @(negedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
